// ==== dv/ccp_peer_model.sv ====
// Peer model: clock source ticks and sync lines from neighbouring units
`timescale 1ns/1ps
module ccp_peer_model
  import ccp_timer_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic [2:0] src_i,
  input wire logic [7:0] n_ticks_i,
  input wire logic go_i,
  input wire logic [4:0] line_i,
  input wire logic level_i,
  output logic [7:0] tick_o,
  output logic [31:0] sync_o
);
  logic [7:0] left_q;
  logic phase_q;
  logic [7:0] one_src;
  logic [31:0] one_line;
  assign one_src = 8'h01 << src_i;
  assign one_line = 32'h0000_0001 << line_i;
  // Unused sources and lines keep toggling, so a wrong decode shows up
  assign tick_o = ({8{phase_q}} & ~one_src) |
                  ((phase_q && left_q != 8'h00) ? one_src : 8'h00);
  assign sync_o = ((phase_q ? 32'hAAAA_AAAA : 32'h5555_5555) & ~one_line) |
                  (level_i ? one_line : 32'h0000_0000);
  always_ff @(posedge ref_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      left_q <= 8'h00;
      phase_q <= 1'b0;
    end
    else
    begin
      phase_q <= ~phase_q;
      if (go_i)
        left_q <= n_ticks_i;
      else if (phase_q && left_q != 8'h00)
        left_q <= left_q - 8'h01;
    end
  end
endmodule

// ==== dv/tb_ccp_time_base.sv ====
// Self-checking testbench for the time base and general purpose timer
`timescale 1ns/1ps
module tb_ccp_time_base
  import ccp_timer_pkg::*;
;
  logic ref_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  reg_req_t req = '0;
  logic [DATA_W-1:0] rdata;
  logic [7:0] ticks;
  logic [31:0] sync_in;
  logic idle = 1'b0;
  timer_evt_t evt;
  logic trig;
  logic [2:0] src = 3'h0;
  logic [7:0] n_ticks = 8'h00;
  logic go = 1'b0;
  logic [4:0] line = 5'h00;
  logic level = 1'b0;
  int failures = 0;
  int tests_run = 0;
  int cycles = 0;
  int n;
  logic [DATA_W-1:0] v;
  logic [DATA_W-1:0] w;
  always #2.5 ref_clk_i = ~ref_clk_i;
  ccp_time_base u_ccp_time_base (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .req_i(req),
    .rdata_o(rdata), .clk_src_tick_i(ticks), .sync_in_i(sync_in), .idle_i(idle),
    .evt_o(evt), .trigger_status_o(trig));
  ccp_peer_model u_ccp_peer_model (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .src_i(src),
    .n_ticks_i(n_ticks), .go_i(go), .line_i(line), .level_i(level), .tick_o(ticks),
    .sync_o(sync_in));
  // ****************************************
  // Helpers
  // ****************************************
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk16(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      failures++;
      $display("BAD %0t data %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    tests_run++;
    if (got !== exp)
    begin
      failures++;
      $display("BAD %0t flag %b expected %b", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge ref_clk_i);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk_i);
    req <= '0;
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge ref_clk_i);
    req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk_i);
    req <= '0;
    #1;
    d = rdata;
  endtask
  // Checks whether the low counter moves over a few cycles
  task automatic moves(input logic exp);
    rd(ADDR_TMRL, v);
    repeat (3) @(posedge ref_clk_i);
    rd(ADDR_TMRL, w);
    chk1(w !== v, exp);
  endtask
  // Cycles between two pulses of one event output
  task automatic gap(input logic hi, input int exp);
    n = 0;
    while ((hi ? evt.compare_event : evt.sync_out) !== 1'b1 && n < 100)
    begin
      @(posedge ref_clk_i);
      #1;
      n++;
    end
    n = 0;
    do
    begin
      @(posedge ref_clk_i);
      #1;
      n++;
    end while ((hi ? evt.compare_event : evt.sync_out) !== 1'b1 && n < 100);
    chk16(16'(n), 16'(exp));
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset();
    rd(ADDR_CON1L, v);
    chk16(v, RESET_VALUE);
    rd(ADDR_TMRL, v);
    chk16(v, RESET_VALUE);
    rd(ADDR_STATL, v);
    chk16(v, RESET_VALUE);
    chk1(trig, 1'b0);
    wr(4'h7, 16'hFFFF);
    rd(4'h7, v);
    chk16(v, 16'h0000);
    wr(ADDR_CON1L, 16'hFFFF);
    rd(ADDR_CON1L, v);
    chk16(v, CON1L_WRITE_MASK);
    wr(ADDR_CON1L, 16'h0000);
  endtask
  task automatic t_dual();
    wr(ADDR_PRL, 16'h0002);
    wr(ADDR_PRH, 16'h0001);
    wr(ADDR_CON1L, 16'h8000);
    gap(1'b0, 3);
    gap(1'b1, 2);
    wr(ADDR_CON1L, 16'h0000);
  endtask
  task automatic t_wide();
    wr(ADDR_CON1L, 16'h0020);
    wr(ADDR_PRH, 16'h0001);
    wr(ADDR_PRL, 16'hFFFF);
    wr(ADDR_TMRL, 16'hFFFC);
    wr(ADDR_TMRH, 16'h0000);
    wr(ADDR_CON1L, 16'h8020);
    n = 0;
    repeat (10)
    begin
      @(posedge ref_clk_i);
      #1;
      if (evt.compare_event !== 1'b0 || evt.sync_out !== 1'b0)
        n++;
    end
    chk16(16'(n), 16'h0000);
    wr(ADDR_CON1L, 16'h0020);
    rd(ADDR_TMRH, v);
    chk16(v, 16'h0001);
    rd(ADDR_TMRL, v);
    chk1(v < 16'h0010, 1'b1);
    wr(ADDR_TMRL, 16'hFFFF);
    wr(ADDR_CON1L, 16'h8020);
    n = 0;
    while (evt.compare_event !== 1'b1 && n < 10)
    begin
      @(posedge ref_clk_i);
      #1;
      n++;
    end
    chk1(evt.compare_event, 1'b1);
    chk1(evt.sync_out, 1'b1);
    wr(ADDR_CON1L, 16'h0000);
  endtask
  task automatic t_clksrc();
    wr(ADDR_PRL, 16'hFFFF);
    // The peer toggles every unselected source, so pick source 3 before enabling
    src <= 3'h3;
    wr(ADDR_TMRL, 16'h0000);
    wr(ADDR_CON1L, 16'h8300);
    moves(1'b0);
    @(posedge ref_clk_i);
    n_ticks <= 8'h05;
    go <= 1'b1;
    @(posedge ref_clk_i);
    go <= 1'b0;
    repeat (20) @(posedge ref_clk_i);
    rd(ADDR_TMRL, v);
    chk16(v, 16'h0005);
  endtask
  task automatic t_sync();
    wr(ADDR_CON1H, 16'h0002);
    wr(ADDR_CON1L, 16'h8000);
    @(posedge ref_clk_i);
    line <= 5'h02;
    level <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    rd(ADDR_TMRL, v);
    chk16(v, 16'h0000);
    @(posedge ref_clk_i);
    level <= 1'b0;
    moves(1'b1);
  endtask
  task automatic t_trig();
    wr(ADDR_CON1H, 16'h0082);
    repeat (2) @(posedge ref_clk_i);
    moves(1'b0);
    chk16(w, 16'h0000);
    chk1(trig, 1'b0);
    @(posedge ref_clk_i);
    level <= 1'b1;
    @(posedge ref_clk_i);
    level <= 1'b0;
    moves(1'b1);
    rd(ADDR_STATL, v);
    chk16(v, 16'h0080);
    wr(ADDR_STATL, 16'h0020);
    #1;
    chk1(trig, 1'b0);
    moves(1'b0);
    chk16(w, 16'h0000);
  endtask
  task automatic t_idle();
    wr(ADDR_CON1H, 16'h0000);
    // Park the driven line on source 0 so no toggling line can clear the timer
    line <= 5'h00;
    wr(ADDR_CON1L, 16'hA000);
    @(posedge ref_clk_i);
    idle <= 1'b1;
    moves(1'b0);
    wr(ADDR_CON1L, 16'h8000);
    moves(1'b1);
    @(posedge ref_clk_i);
    idle <= 1'b0;
  endtask
  task automatic t_mode();
    logic [DATA_W-1:0] cfg [3];
    cfg = '{16'h8001, 16'h8010, 16'h0000};
    foreach (cfg[i])
    begin
      wr(ADDR_CON1L, cfg[i]);
      moves(1'b0);
    end
    wr(ADDR_CON1L, 16'h8000);
    moves(1'b1);
  endtask
  // ****************************************
  // Main sequence and timeout
  // ****************************************
  always @(posedge ref_clk_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      failures++;
      $display("BAD %0t timeout", $time);
      print_verdict();
    end
  end
  initial
  begin
    repeat (8) @(posedge ref_clk_i);
    sys_rst_i <= 1'b0;
    t_reset();
    t_dual();
    t_wide();
    t_clksrc();
    t_sync();
    t_trig();
    t_idle();
    t_mode();
    print_verdict();
  end
endmodule

// ==== rtl/ccp_clock_gen.sv ====
// Time base clock generator: picks one of eight tick sources
`timescale 1ns/1ps
module ccp_clock_gen
  import ccp_timer_pkg::*;
#(
  parameter int NUM_SRC = 8
)
(
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic [NUM_SRC-1:0] src_tick_i,
  input wire logic [CLK_SEL_W-1:0] clk_sel_i,
  input wire logic run_i,
  output logic tick_o
);

  typedef struct packed {
    logic tick;
  } gen_state_t;

  gen_state_t s_q;
  gen_state_t s_d;

  // Source zero is the system clock itself, so it ticks every cycle
  always_comb
  begin
    s_d = s_q;
    if (clk_sel_i == CLK_SYSTEM)
    begin
      s_d.tick = run_i;
    end
    else
    begin
      s_d.tick = run_i & src_tick_i[clk_sel_i];
    end
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign tick_o = s_q.tick;

endmodule

// ==== rtl/ccp_time_base.sv ====
// Time base and general purpose timer of the capture/compare/timer unit
`timescale 1ns/1ps
module ccp_time_base
  import ccp_timer_pkg::*;
#(
  parameter int NUM_CLK_SRC = 8,
  parameter int NUM_SYNC_SRC = 32
)
(
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire reg_req_t req_i,
  output logic [DATA_W-1:0] rdata_o,
  input wire logic [NUM_CLK_SRC-1:0] clk_src_tick_i,
  input wire logic [NUM_SYNC_SRC-1:0] sync_in_i,
  input wire logic idle_i,
  output timer_evt_t evt_o,
  output logic trigger_status_o
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [DATA_W-1:0] con1l;
    logic [DATA_W-1:0] con1h;
    logic [DATA_W-1:0] con2l;
    logic [DATA_W-1:0] con2h;
    logic [DATA_W-1:0] con3l;
    logic [DATA_W-1:0] con3h;
    logic trigger_status;
    logic [DATA_W-1:0] counter_low;
    logic [DATA_W-1:0] counter_high;
    logic [DATA_W-1:0] period_low;
    logic [DATA_W-1:0] period_high;
    logic [DATA_W-1:0] cmp_a_low;
    logic [DATA_W-1:0] cmp_a_high;
    logic [DATA_W-1:0] cmp_b_low;
    logic [DATA_W-1:0] cmp_b_high;
    logic [DATA_W-1:0] rdata;
    timer_evt_t evt;
  } tb_state_t;

  tb_state_t s_q;
  tb_state_t s_d;

  logic tick;
  logic module_enable;
  logic idle_stop;
  logic wide_counter_select;
  logic capture_select;
  logic [MODE_W-1:0] operating_mode_field;
  logic [CLK_SEL_W-1:0] clock_source_select;
  logic [SYNC_SEL_W-1:0] sync_sel;
  logic trigger_enable;
  logic timer_mode;
  logic active;
  logic run;
  logic sync_level;
  logic trig_hit;
  logic trig_clear;
  logic sync_clear;
  logic held;
  logic cnt_en;
  logic sw_cnt_wr;
  logic low_match;
  logic high_match;
  logic [2*DATA_W-1:0] wide_count;

  // ****************************************
  // Control decode
  // ****************************************
  assign module_enable = s_q.con1l[MODULE_ENABLE_BIT];
  assign idle_stop = s_q.con1l[IDLE_STOP_BIT];
  assign wide_counter_select = s_q.con1l[WIDE_SEL_BIT];
  assign capture_select = s_q.con1l[CAPTURE_SEL_BIT];
  assign operating_mode_field = s_q.con1l[MODE_LSB +: MODE_W];
  assign clock_source_select = s_q.con1l[CLK_SEL_LSB +: CLK_SEL_W];
  assign sync_sel = s_q.con1h[SYNC_SEL_LSB +: SYNC_SEL_W];
  assign trigger_enable = s_q.con1h[TRIGGER_EN_BIT];

  // Capture and compare modes are not built here, so the counter only runs in timer mode
  assign timer_mode = !capture_select && (operating_mode_field == MODE_TIMER);
  assign active = module_enable && timer_mode;
  assign run = active && !(idle_i && idle_stop);

  // Code 11111 selects nothing, so with that code no sync line can clear the timer
  assign sync_level = (sync_sel != SYNC_NONE) && sync_in_i[sync_sel];

  assign trig_hit = active && trigger_enable && sync_level;
  assign trig_clear = req_i.wr && (req_i.addr == ADDR_STATL)
    && req_i.wdata[TRIGGER_CLEAR_BIT];
  assign sync_clear = active && !trigger_enable && sync_level;
  assign held = trigger_enable && !s_q.trigger_status;
  assign cnt_en = tick && !held && !sync_clear;
  assign sw_cnt_wr = req_i.wr && ((req_i.addr == ADDR_TMRL) || (req_i.addr == ADDR_TMRH));

  assign low_match = s_q.counter_low == s_q.period_low;
  assign high_match = s_q.counter_high == s_q.period_high;
  assign wide_count = {s_q.counter_high, s_q.counter_low} + 32'h0000_0001;

  ccp_clock_gen #(
    .NUM_SRC(NUM_CLK_SRC)
  ) u_clock_gen (
    .ref_clk_i(ref_clk_i),
    .sys_rst_i(sys_rst_i),
    .src_tick_i(clk_src_tick_i),
    .clk_sel_i(clock_source_select),
    .run_i(run),
    .tick_o(tick)
  );

  // ****************************************
  // Read mux
  // ****************************************
  function automatic logic [DATA_W-1:0] read_reg(input tb_state_t st,
                                                 input logic [ADDR_W-1:0] a);
    logic [DATA_W-1:0] v;
    v = RESET_VALUE;
    case (a)
      ADDR_CON1L: v = st.con1l;
      ADDR_CON1H: v = st.con1h;
      ADDR_CON2L: v = st.con2l;
      ADDR_CON2H: v = st.con2h;
      ADDR_CON3L: v = st.con3l;
      ADDR_CON3H: v = st.con3h;
      ADDR_STATL: v[TRIGGER_STATUS_BIT] = st.trigger_status;
      ADDR_TMRL: v = st.counter_low;
      ADDR_TMRH: v = st.counter_high;
      ADDR_PRL: v = st.period_low;
      ADDR_PRH: v = st.period_high;
      ADDR_RAL: v = st.cmp_a_low;
      ADDR_RAH: v = st.cmp_a_high;
      ADDR_RBL: v = st.cmp_b_low;
      ADDR_RBH: v = st.cmp_b_high;
      default: v = RESET_VALUE;
    endcase
    return v;
  endfunction

  // ****************************************
  // Next state
  // ****************************************
  always_comb
  begin
    s_d = s_q;
    s_d.evt = '0;
    s_d.rdata = req_i.rd ? read_reg(s_q, req_i.addr) : RESET_VALUE;

    // An arriving trigger beats a simultaneous clear so the event is not lost
    if (trig_clear)
    begin
      s_d.trigger_status = 1'b0;
    end
    if (trig_hit)
    begin
      s_d.trigger_status = 1'b1;
    end

    if (active && (sync_clear || held || trig_clear))
    begin
      s_d.counter_low = RESET_VALUE;
      s_d.counter_high = RESET_VALUE;
    end
    else if (cnt_en && wide_counter_select)
    begin
      if (low_match && high_match)
      begin
        s_d.counter_low = RESET_VALUE;
        s_d.counter_high = RESET_VALUE;
        s_d.evt.sync_out = 1'b1;
        s_d.evt.compare_event = 1'b1;
      end
      else
      begin
        s_d.counter_low = wide_count[DATA_W-1:0];
        s_d.counter_high = wide_count[2*DATA_W-1:DATA_W];
      end
    end
    else if (cnt_en)
    begin
      // Dual mode: primary on the low half owns sync out
      if (low_match)
      begin
        s_d.counter_low = RESET_VALUE;
        s_d.evt.sync_out = 1'b1;
      end
      else
      begin
        s_d.counter_low = s_q.counter_low + 16'h0001;
      end
      // Secondary on the high half only raises the compare event
      if (high_match)
      begin
        s_d.counter_high = RESET_VALUE;
        s_d.evt.compare_event = 1'b1;
      end
      else
      begin
        s_d.counter_high = s_q.counter_high + 16'h0001;
      end
    end

    // Software writes land last and win over counting
    if (req_i.wr)
    begin
      case (req_i.addr)
        ADDR_CON1L: s_d.con1l = req_i.wdata & CON1L_WRITE_MASK;
        ADDR_CON1H: s_d.con1h = req_i.wdata;
        ADDR_CON2L: s_d.con2l = req_i.wdata;
        ADDR_CON2H: s_d.con2h = req_i.wdata;
        ADDR_CON3L: s_d.con3l = req_i.wdata;
        ADDR_CON3H: s_d.con3h = req_i.wdata;
        ADDR_TMRL: s_d.counter_low = req_i.wdata;
        ADDR_TMRH: s_d.counter_high = req_i.wdata;
        ADDR_PRL: s_d.period_low = req_i.wdata;
        ADDR_PRH: s_d.period_high = req_i.wdata;
        ADDR_RAL: s_d.cmp_a_low = req_i.wdata;
        ADDR_RAH: s_d.cmp_a_high = req_i.wdata;
        ADDR_RBL: s_d.cmp_b_low = req_i.wdata;
        ADDR_RBH: s_d.cmp_b_high = req_i.wdata;
        default: s_d.con1h = s_d.con1h;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign rdata_o = s_q.rdata;
  assign evt_o = s_q.evt;
  assign trigger_status_o = s_q.trigger_status;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (sys_rst_i);

  a_low_period_wrap: assert property (
    cnt_en && !wide_counter_select && low_match && !sw_cnt_wr && !trig_clear
    |=> s_q.counter_low == 16'h0000 && evt_o.sync_out)
    else $error("primary counter did not wrap at its period");

  a_high_compare_evt: assert property (
    cnt_en && !wide_counter_select && high_match && !sw_cnt_wr && !trig_clear
    |=> evt_o.compare_event && s_q.counter_high == 16'h0000)
    else $error("secondary period match gave no compare event");

  a_wide_carry_one: assert property (
    cnt_en && wide_counter_select && s_q.counter_low == COUNT_ALL_ONES && !high_match
    && !sw_cnt_wr && !trig_clear
    |=> s_q.counter_low == 16'h0000 && s_q.counter_high == $past(s_q.counter_high) + 16'h0001)
    else $error("low overflow did not step the high counter by one");

  a_sync_clears_timer: assert property (
    sync_clear && !sw_cnt_wr |=> s_q.counter_low == 16'h0000 && s_q.counter_high == 16'h0000)
    else $error("sync input did not clear the timer");

  a_trigger_hold_zero: assert property (
    active && trigger_enable && !s_q.trigger_status && !sw_cnt_wr
    |=> s_q.counter_low == 16'h0000 && s_q.counter_high == 16'h0000)
    else $error("timer moved before its trigger");

  a_trigger_status_set: assert property (
    trig_hit |=> trigger_status_o)
    else $error("trigger did not set trigger status");

  a_trigger_status_keep: assert property (
    trigger_status_o && !trig_clear |=> trigger_status_o)
    else $error("trigger status lost without a trigger clear");

  a_trigger_clear_drop: assert property (
    trig_clear && !trig_hit |=> !trigger_status_o)
    else $error("trigger clear did not drop trigger status");

  a_disabled_stable: assert property (
    !module_enable ##1 (!module_enable && !sw_cnt_wr) |=> $stable(s_q.counter_low))
    else $error("counter moved while the unit is disabled");

  a_idle_halts: assert property (
    (idle_i && idle_stop) ##1 (idle_i && idle_stop && !sw_cnt_wr && !trig_clear)
    |=> $stable(s_q.counter_low) && $stable(s_q.counter_high))
    else $error("counter ran in idle with idle stop set");

  a_system_clock_tick: assert property (
    run && clock_source_select == CLK_SYSTEM |=> tick)
    else $error("system clock source gave no tick");

  a_other_mode_stops: assert property (
    !timer_mode ##1 (!timer_mode && !sw_cnt_wr) |=> $stable(s_q.counter_low))
    else $error("counter ran outside timer mode");

endmodule

// ==== rtl/ccp_timer_pkg.sv ====
// Constants and carriers shared by the time base and timer block
package ccp_timer_pkg;

  // ****************************************
  // Bus shape
  // ****************************************
  localparam int DATA_W = 16;
  localparam int ADDR_W = 4;

  // ****************************************
  // Register offsets (word index)
  // ****************************************
  localparam logic [ADDR_W-1:0] ADDR_CON1L = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_CON1H = 4'h1;
  localparam logic [ADDR_W-1:0] ADDR_CON2L = 4'h2;
  localparam logic [ADDR_W-1:0] ADDR_CON2H = 4'h3;
  localparam logic [ADDR_W-1:0] ADDR_CON3L = 4'h4;
  localparam logic [ADDR_W-1:0] ADDR_CON3H = 4'h5;
  localparam logic [ADDR_W-1:0] ADDR_STATL = 4'h6;
  localparam logic [ADDR_W-1:0] ADDR_TMRL = 4'h8;
  localparam logic [ADDR_W-1:0] ADDR_TMRH = 4'h9;
  localparam logic [ADDR_W-1:0] ADDR_PRL = 4'hA;
  localparam logic [ADDR_W-1:0] ADDR_PRH = 4'hB;
  localparam logic [ADDR_W-1:0] ADDR_RAL = 4'hC;
  localparam logic [ADDR_W-1:0] ADDR_RAH = 4'hD;
  localparam logic [ADDR_W-1:0] ADDR_RBL = 4'hE;
  localparam logic [ADDR_W-1:0] ADDR_RBH = 4'hF;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int MODULE_ENABLE_BIT = 15;
  localparam int IDLE_STOP_BIT = 13;
  localparam int CLK_SEL_LSB = 8;
  localparam int CLK_SEL_W = 3;
  localparam int WIDE_SEL_BIT = 5;
  localparam int CAPTURE_SEL_BIT = 4;
  localparam int MODE_LSB = 0;
  localparam int MODE_W = 4;
  localparam int SYNC_SEL_LSB = 0;
  localparam int SYNC_SEL_W = 5;
  localparam int TRIGGER_EN_BIT = 7;
  localparam int TRIGGER_STATUS_BIT = 7;
  localparam int TRIGGER_CLEAR_BIT = 5;

  // ****************************************
  // Values
  // ****************************************
  localparam logic [DATA_W-1:0] RESET_VALUE = 16'h0000;
  localparam logic [DATA_W-1:0] CON1L_WRITE_MASK = 16'hAFFF;
  localparam logic [CLK_SEL_W-1:0] CLK_SYSTEM = 3'h0;
  localparam logic [MODE_W-1:0] MODE_TIMER = 4'h0;
  localparam logic [SYNC_SEL_W-1:0] SYNC_NONE = 5'h1F;
  localparam logic [DATA_W-1:0] COUNT_ALL_ONES = 16'hFFFF;

  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  typedef struct packed {
    logic sync_out;
    logic compare_event;
  } timer_evt_t;

endpackage
